// File: pkg/fsps_pkg.sv
package fsps_pkg;

   // ------------------------------------------------------------
   // clock and programming time
   // ------------------------------------------------------------
   localparam int CLK_MHZ         = 50;
   localparam int PROG_TIME_US    = 3700;
   localparam int PROG_CYCLES_DEF = PROG_TIME_US * CLK_MHZ;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;

   localparam int CB_SELF_PROGRAM_ENABLE  = 0;
   localparam int CB_PGERS  = 1;
   localparam int CB_PGWRT  = 2;
   localparam int CB_LOCK_BIT_SET = 3;
   localparam int CB_REEN   = 4;
   localparam int CB_RWW_BUSY_FLAG  = 6;
   localparam int CB_IE     = 7;

   localparam int SB_BUSY   = 0;
   localparam int SB_HALT   = 1;
   localparam int SB_EEBUSY = 2;
   localparam int SB_LOCK   = 8;

   // command codes in control bits 4:0
   localparam logic [4:0] CMD_LOAD  = 5'h01;
   localparam logic [4:0] CMD_ERASE = 5'h03;
   localparam logic [4:0] CMD_WRITE = 5'h05;
   localparam logic [4:0] CMD_LOCK  = 5'h09;
   localparam logic [4:0] CMD_REEN  = 5'h11;

   // ------------------------------------------------------------
   // timed windows, pointer layout, fuse and lock reads
   // ------------------------------------------------------------
   localparam logic [2:0] SPM_WINDOW = 3'h4;
   localparam logic [2:0] LPM_WINDOW = 3'h3;

   localparam int Z_PAGE_MSB = 14;
   localparam int Z_PAGE_LSB = 7;
   localparam int Z_WORD_MSB = 6;
   localparam int Z_WORD_LSB = 1;
   localparam logic [7:0] NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 8'hE0;

   localparam logic [15:0] Z_FUSE_LOW  = 16'h0000;
   localparam logic [15:0] Z_LOCK      = 16'h0001;
   localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
   localparam logic [5:0]  LOCK_RESET  = 6'h3F;
   localparam int BOOT_LOCK_MSB = 5;
   localparam int BOOT_LOCK_LSB = 2;

   localparam int BUF_WORDS = 64;
   localparam int BUF_IDX_W = 6;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_ARMED = 3'b010,
      ST_BUSY  = 3'b100
   } fsps_state_type;

   typedef enum logic [1:0] {
      OP_ERASE = 2'h0,
      OP_WRITE = 2'h1,
      OP_LOCK  = 2'h2
   } fsps_op_type;

endpackage

// File: core/fsps_op_timer.sv
module fsps_op_timer
   import fsps_pkg::*;
#(
   parameter int CYCLES = PROG_CYCLES_DEF
) (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rstN,
   // control
   input  wire logic start,
   output logic      done
);

   localparam int CW = $clog2(CYCLES + 1);

   logic [CW-1:0] count_r;
   logic          run_r;

   // counts one flash operation; done is a one-cycle pulse at its end
   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         count_r <= '0;
         run_r   <= 1'b0;
      end else if (start) begin
         count_r <= '0;
         run_r   <= 1'b1;
      end else if (run_r) begin
         count_r <= count_r + CW'(1);
         if (count_r == CW'(CYCLES - 1)) begin
            run_r <= 1'b0;
         end
      end
   end

   assign done = run_r && (count_r == CW'(CYCLES - 1));

endmodule // fsps_op_timer

// File: core/fsps_page_buffer.sv
module fsps_page_buffer
   import fsps_pkg::*;
(
   // clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 rstN,
   // load side
   input  wire logic                 wrEn,
   input  wire logic [BUF_IDX_W-1:0] wrIdx,
   input  wire logic [15:0]          wrData,
   input  wire logic                 clear,
   // flash side
   input  wire logic [BUF_IDX_W-1:0] rdIdx,
   output logic      [15:0]          rdData,
   output logic                      rdLoaded
);

   logic [15:0]          word_r   [BUF_WORDS];
   logic [BUF_WORDS-1:0] loaded_r;

   // a load in the same cycle as a clear is kept
   for (genvar i = 0; i < BUF_WORDS; i++) begin : g_slot
      always_ff @(posedge ref_clk or negedge rstN) begin
         if (!rstN) begin
            word_r[i]   <= 16'hFFFF;
            loaded_r[i] <= 1'b0;
         end else if (wrEn && wrIdx == BUF_IDX_W'(i)) begin
            word_r[i]   <= wrData;
            loaded_r[i] <= 1'b1;
         end else if (clear) begin
            word_r[i]   <= 16'hFFFF;
            loaded_r[i] <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         rdData   <= 16'hFFFF;
         rdLoaded <= 1'b0;
      end else begin
         rdData   <= word_r[rdIdx];
         rdLoaded <= loaded_r[rdIdx];
      end
   end

endmodule // fsps_page_buffer

// File: core/fsps_sequencer.sv
module fsps_sequencer
   import fsps_pkg::*;
#(
   parameter int         PROG_CYCLES = PROG_CYCLES_DEF,
   parameter logic [5:0] LOCK_INIT   = LOCK_RESET
) (
   // clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 resetn,
   // apb slave
   input  wire logic [7:0]           paddr,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // cpu core
   input  wire logic                 spmStrobe,
   input  wire logic                 lpmStrobe,
   input  wire logic [15:0]          zPointer,
   input  wire logic [7:0]           r0Data,
   input  wire logic [7:0]           r1Data,
   output logic                      lpmOverride,
   output logic      [7:0]           lpmData,
   output logic                      cpuHalt,
   output logic                      rwwReadBlock,
   output logic                      spmIrq,
   // eeprom and fuses
   input  wire logic                 eepromWriteBusy,
   input  wire logic [7:0]           fuseLowByte,
   input  wire logic [7:0]           fuseHighByte,
   // flash array
   output logic                      flashOpActive,
   output logic      [1:0]           flashOpKind,
   output logic      [7:0]           flashPage,
   input  wire logic [BUF_IDX_W-1:0] bufRdIdx,
   output logic      [15:0]          bufRdData,
   output logic                      bufRdLoaded
);

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic [1:0] rstPipe_r;
   logic       rstN;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rstPipe_r <= 2'b00;
      end else begin
         rstPipe_r <= {rstPipe_r[0], 1'b1};
      end
   end

   assign rstN = rstPipe_r[1];

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   fsps_state_type state_r;
   fsps_op_type    opKind_r;
   logic [4:0]     cmd_r;
   logic [2:0]     window_r;
   logic [7:0]     page_r;
   logic           haltTarget_r;
   logic           rww_busy_flag_r;
   logic           ie_r;
   logic [5:0]     lockBits_r;
   logic [3:0]     lockR0_r;
   logic           eeBusyPrev_r;
   logic [7:0]     lpmData_r;
   logic           lpmOverride_r;

   logic        apbWr;
   logic        ctrlWr;
   logic        cmdAccept;
   logic        spmHit;
   logic        lpmRead;
   logic        expire;
   logic        opStart;
   logic        timerDone;
   logic        bufClear;
   logic [7:0]  zPage;
   logic [7:0]  ctrlView;

   function automatic logic isMapped(input logic [7:0] addr);
      return (addr == OFS_CTRL) || (addr == OFS_STAT);
   endfunction

   // fuse and lock bytes come back inverted-logic: programmed reads 0
   function automatic logic [7:0] configByte(input logic [15:0] z, input logic [5:0] lock,
                                             input logic [7:0] fLow, input logic [7:0] fHigh);
      if (z == Z_LOCK) begin
         return {2'b11, lock};
      end else if (z == Z_FUSE_LOW) begin
         return fLow;
      end else if (z == Z_FUSE_HIGH) begin
         return fHigh;
      end
      return 8'hFF;
   endfunction

   // ------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------
   assign apbWr     = psel && penable && pwrite;
   assign ctrlWr    = apbWr && (paddr == OFS_CTRL);
   assign cmdAccept = ctrlWr && (state_r == ST_IDLE) && !eepromWriteBusy
                      && pwdata[CB_SELF_PROGRAM_ENABLE];
   assign spmHit    = (state_r == ST_ARMED) && spmStrobe && (window_r < SPM_WINDOW);
   assign lpmRead   = (state_r == ST_ARMED) && lpmStrobe && cmd_r[CB_LOCK_BIT_SET]
                      && (window_r < LPM_WINDOW) && !eepromWriteBusy;
   assign expire    = (state_r == ST_ARMED) && !spmHit && !lpmRead
                      && (window_r == SPM_WINDOW - 3'h1);
   assign opStart   = spmHit && ((cmd_r == CMD_ERASE) || (cmd_r == CMD_WRITE)
                      || (cmd_r == CMD_LOCK));
   assign zPage     = zPointer[Z_PAGE_MSB:Z_PAGE_LSB];

   // ------------------------------------------------------------
   // sequence state
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         state_r <= ST_IDLE;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (cmdAccept) begin
                  state_r <= ST_ARMED;
               end
            end
            ST_ARMED: begin
               if (opStart) begin
                  state_r <= ST_BUSY;
               end else if (spmHit || lpmRead || expire) begin
                  state_r <= ST_IDLE;
               end
            end
            ST_BUSY: begin
               if (timerDone) begin
                  state_r <= ST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         cmd_r    <= 5'h00;
         window_r <= 3'h0;
      end else if (cmdAccept) begin
         cmd_r    <= pwdata[4:0];
         window_r <= 3'h0;
      end else if (state_r == ST_ARMED) begin
         window_r <= window_r + 3'h1;
      end
   end

   // ------------------------------------------------------------
   // operation latch
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         opKind_r     <= OP_ERASE;
         page_r       <= 8'h00;
         haltTarget_r <= 1'b0;
         lockR0_r     <= 4'hF;
      end else if (opStart) begin
         page_r   <= zPage;
         lockR0_r <= r0Data[BOOT_LOCK_MSB:BOOT_LOCK_LSB];
         if (cmd_r == CMD_LOCK) begin
            opKind_r     <= OP_LOCK;
            haltTarget_r <= 1'b0;
         end else begin
            opKind_r     <= (cmd_r == CMD_ERASE) ? OP_ERASE : OP_WRITE;
            haltTarget_r <= (zPage >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE);
         end
      end
   end

   fsps_op_timer #(
      .CYCLES (PROG_CYCLES)
   ) u_timer (
      .ref_clk (ref_clk),
      .rstN    (rstN),
      .start   (opStart),
      .done    (timerDone)
   );

   // ------------------------------------------------------------
   // rww busy flag, lock bits, interrupt enable
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         rww_busy_flag_r <= 1'b0;
      end else if (opStart && cmd_r != CMD_LOCK) begin
         rww_busy_flag_r <= 1'b1;
      end else if (spmHit && cmd_r == CMD_REEN) begin
         rww_busy_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         lockBits_r <= LOCK_INIT;
      end else if (timerDone && opKind_r == OP_LOCK) begin
         lockBits_r[BOOT_LOCK_MSB:BOOT_LOCK_LSB] <=
            lockBits_r[BOOT_LOCK_MSB:BOOT_LOCK_LSB] & lockR0_r;
      end
   end

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         ie_r <= 1'b0;
      end else if (ctrlWr) begin
         ie_r <= pwdata[CB_IE];
      end
   end

   assign spmIrq = ie_r && (state_r == ST_IDLE);

   // ------------------------------------------------------------
   // temporary page buffer
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         eeBusyPrev_r <= 1'b0;
      end else begin
         eeBusyPrev_r <= eepromWriteBusy;
      end
   end

   assign bufClear = (timerDone && opKind_r == OP_WRITE)
                     || (cmdAccept && pwdata[CB_REEN])
                     || (eepromWriteBusy && !eeBusyPrev_r);

   fsps_page_buffer u_buffer (
      .ref_clk  (ref_clk),
      .rstN     (rstN),
      .wrEn     (spmHit && cmd_r == CMD_LOAD),
      .wrIdx    (zPointer[Z_WORD_MSB:Z_WORD_LSB]),
      .wrData   ({r1Data, r0Data}),
      .clear    (bufClear),
      .rdIdx    (bufRdIdx),
      .rdData   (bufRdData),
      .rdLoaded (bufRdLoaded)
   );

   // ------------------------------------------------------------
   // lock and fuse reads
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         lpmData_r     <= 8'hFF;
         lpmOverride_r <= 1'b0;
      end else begin
         lpmOverride_r <= lpmRead;
         if (lpmRead) begin
            lpmData_r <= configByte(zPointer, lockBits_r, fuseLowByte, fuseHighByte);
         end
      end
   end

   assign lpmOverride   = lpmOverride_r;
   assign lpmData       = lpmData_r;
   assign cpuHalt       = (state_r == ST_BUSY) && haltTarget_r;
   assign rwwReadBlock  = rww_busy_flag_r;
   assign flashOpActive = (state_r == ST_BUSY);
   assign flashOpKind   = opKind_r;
   assign flashPage     = page_r;

   // ------------------------------------------------------------
   // apb register access
   // ------------------------------------------------------------
   assign ctrlView = {ie_r, rww_busy_flag_r, 1'b0, (state_r == ST_IDLE) ? 5'h00 : cmd_r};
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !isMapped(paddr);

   always_comb begin
      prdata = 32'h0000_0000;
      if (psel && isMapped(paddr)) begin
         if (paddr == OFS_CTRL) begin
            prdata[7:0] = ctrlView;
         end else begin
            prdata[SB_BUSY]                = (state_r == ST_BUSY);
            prdata[SB_HALT]                = cpuHalt;
            prdata[SB_EEBUSY]              = eepromWriteBusy;
            prdata[SB_LOCK+5:SB_LOCK]      = lockBits_r;
         end
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstN);

   sequence armedQuiet_s;
      cmdAccept ##1 (!spmStrobe && !lpmStrobe) [*4];
   endsequence

   sequence eraseStart_s;
      opStart && cmd_r == CMD_ERASE;
   endsequence

   window_timeout_a: assert property (armedQuiet_s |=> state_r == ST_IDLE)
      else $error("enable bits not cleared after four idle cycles");

   erase_blocks_rww_a: assert property (eraseStart_s |=> rwwReadBlock && flashOpActive)
      else $error("erase start did not block rww section");

   page_latched_a: assert property (opStart |=> flashPage == $past(zPage))
      else $error("target page not latched at start");

   page_stable_a: assert property (flashOpActive && $past(flashOpActive) |-> $stable(flashPage))
      else $error("target page moved during operation");

   no_read_while_write_section_halts_cpu_a: assert property (opStart && cmd_r != CMD_LOCK && zPage >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE
                                      |=> cpuHalt)
      else $error("cpu not halted for no_read_while_write_section target");

   lock_no_halt_a: assert property (flashOpActive && opKind_r == OP_LOCK |-> !cpuHalt)
      else $error("cpu halted during lock programming");

   rww_busy_flag_holds_a: assert property (rwwReadBlock && !(spmHit && cmd_r == CMD_REEN)
                                   |=> rwwReadBlock)
      else $error("rww busy flag dropped without re-enable");

   ee_blocks_cmd_a: assert property (eepromWriteBusy && state_r == ST_IDLE |=> state_r == ST_IDLE)
      else $error("command taken during eeprom write");

   lock_read_a: assert property (lpmRead && zPointer == Z_LOCK
                                 |=> lpmOverride && lpmData == {2'b11, $past(lockBits_r)}
                                     && state_r == ST_IDLE)
      else $error("lock byte read wrong");

   done_clears_en_a: assert property (timerDone |=> state_r == ST_IDLE ##0 spmIrq == ie_r)
      else $error("enable bit not cleared at completion");

endmodule // fsps_sequencer

// File: dv/fsps_cpu_model.sv
module fsps_cpu_model (
   // clock
   input  wire logic ref_clk,
   // program memory instruction side
   output logic        spmStrobe,
   output logic        lpmStrobe,
   output logic [15:0] zPointer,
   output logic [7:0]  r0Data,
   output logic [7:0]  r1Data
);
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------
   // boot loader instruction issue
   // ------------------------------------------------------------
   initial begin
      spmStrobe = 1'b0;
      lpmStrobe = 1'b0;
      zPointer  = 16'h0000;
      r0Data    = 8'h00;
      r1Data    = 8'h00;
   end

   // called just after the control write; gap idle cycles model a slow core
   task automatic issue(input logic isLpm, input logic [15:0] z, input logic [7:0] r0,
                        input logic [7:0] r1, input int gap);
      // page only in z, spare bits zero, same page for erase and write
      // lock setting uses z 0001 and r0 spare bits one
      // each slot loaded once per buffer clear, eeprom idle checked by caller
      zPointer <= z;
      r0Data   <= r0;
      r1Data   <= r1;
      repeat (gap) @(posedge ref_clk);
      if (isLpm) begin
         lpmStrobe <= 1'b1;
      end else begin
         spmStrobe <= 1'b1;
      end
      @(posedge ref_clk);
      spmStrobe <= 1'b0;
      lpmStrobe <= 1'b0;
      // operands move on at once, so the device must latch what it needs
      zPointer  <= ~z;
      r0Data    <= ~r0;
      r1Data    <= ~r1;
   endtask
endmodule // fsps_cpu_model

// File: dv/flash_self_program_sequencer_test.sv
module flash_self_program_sequencer_test;
   import fsps_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------
   // signals and instances
   // ------------------------------------------------------------
   logic        ref_clk = 1'b0;
   logic        resetn  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [31:0] pwdata  = 32'h0;
   logic        eeBusy  = 1'b0;
   logic [5:0]  rdIdx   = 6'h00;
   logic        slvErr;
   wire  [31:0] prdata;
   wire         pready, pslverr, spm, lpm, lpmOvr, cpuHalt, rwwBlk, spmIrq, opAct, bufLd;
   wire  [15:0] z, bufData;
   wire  [7:0]  r0, r1, lpmData, page;
   wire  [1:0]  opKind;
   int          mismatches = 0;
   int          checked    = 0;
   int          cycles     = 0;
   logic [15:0] fz [3] = '{16'h0001, 16'h0000, 16'h0003};
   logic [7:0]  fe [3] = '{8'hFF, 8'h9E, 8'h4C};

   always #10 ref_clk = ~ref_clk;

   fsps_cpu_model i_fsps_cpu_model (.ref_clk(ref_clk), .spmStrobe(spm), .lpmStrobe(lpm), .zPointer(z),
                                    .r0Data(r0), .r1Data(r1));

   fsps_sequencer #(.PROG_CYCLES(8)) i_fsps_sequencer (
      .ref_clk(ref_clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .spmStrobe(spm), .lpmStrobe(lpm),
      .zPointer(z), .r0Data(r0), .r1Data(r1), .lpmOverride(lpmOvr), .lpmData(lpmData), .cpuHalt(cpuHalt),
      .rwwReadBlock(rwwBlk), .spmIrq(spmIrq), .eepromWriteBusy(eeBusy), .fuseLowByte(8'h9E),
      .fuseHighByte(8'h4C), .flashOpActive(opAct), .flashOpKind(opKind), .flashPage(page),
      .bufRdIdx(rdIdx), .bufRdData(bufData), .bufRdLoaded(bufLd));

   // ------------------------------------------------------------
   // access tasks
   // ------------------------------------------------------------
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // one apb transfer, then one idle edge so psel is never driven twice at once
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd      = prdata;
      slvErr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic wr(input logic [31:0] d);
      logic [31:0] x;
      apb(1'b1, OFS_CTRL, d, x);
   endtask

   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] x;
      apb(1'b0, a, 32'h0, x);
      check(x, exp);
   endtask

   task automatic waitIdle();
      logic [31:0] x;
      do apb(1'b0, OFS_CTRL, 32'h0, x); while (x[CB_SELF_PROGRAM_ENABLE] !== 1'b0);
   endtask

   task automatic cmd(input logic [31:0] c, input logic isLpm, input logic [15:0] zv, input logic [7:0] r0v,
                      input logic [7:0] r1v, input int gap);
      wr(c);
      i_fsps_cpu_model.issue(isLpm, zv, r0v, r1v, gap);
      @(posedge ref_clk);
   endtask

   task automatic bufChk(input logic [5:0] i, input logic [15:0] d, input logic ld);
      rdIdx <= i;
      repeat (3) @(posedge ref_clk);
      check({15'h0, bufLd, bufData}, {15'h0, ld, d});
   endtask

   task automatic endT(input string s);
      $display("test done: %s", s);
   endtask

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         mismatches++;
         print_verdict();
      end
   end

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      repeat (12) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rdChk(OFS_STAT, 32'h3F00);
      bufChk(6'h05, 16'hFFFF, 1'b0);
      rdChk(8'h0C, 32'h0);
      check({31'h0, slvErr}, 32'h1);
      endT("reset");
      foreach (fz[i]) begin
         cmd(32'h09, 1'b1, fz[i], 8'hFF, 8'hFF, 0);
         check({lpmOvr, lpmData}, {1'b1, fe[i]});
         rdChk(OFS_CTRL, 32'h0);
      end
      wr(32'h09);
      repeat (4) @(posedge ref_clk);
      rdChk(OFS_CTRL, 32'h0);
      endT("fuse and lock read");
      cmd(32'h01, 1'b0, 16'h000A, 8'h5A, 8'hA5, 2);
      bufChk(6'h05, 16'hA55A, 1'b1);
      cmd(32'h83, 1'b0, 16'h0800, 8'h00, 8'h00, 1);
      check({opAct, rwwBlk, cpuHalt, spmIrq, opKind, page}, {4'b1100, OP_ERASE, 8'h10});
      rdChk(OFS_CTRL, 32'hC3);
      waitIdle();
      check({rwwBlk, spmIrq, opAct}, 3'b110);
      bufChk(6'h05, 16'hA55A, 1'b1);
      cmd(32'h11, 1'b0, 16'h0000, 8'h00, 8'h00, 0);
      check({rwwBlk, spmIrq}, 2'b00);
      bufChk(6'h05, 16'hFFFF, 1'b0);
      endT("erase");
      cmd(32'h01, 1'b0, 16'h7000, 8'h34, 8'h12, 0);
      cmd(32'h03, 1'b0, 16'h7000, 8'h00, 8'h00, 0);
      check({31'h0, cpuHalt}, 32'h1);
      waitIdle();
      bufChk(6'h00, 16'h1234, 1'b1);
      cmd(32'h05, 1'b0, 16'h7000, 8'h00, 8'h00, 2);
      check({opAct, rwwBlk, cpuHalt, opKind, page}, {3'b111, OP_WRITE, 8'hE0});
      waitIdle();
      check({rwwBlk, cpuHalt}, 2'b10);
      bufChk(6'h00, 16'hFFFF, 1'b0);
      cmd(32'h11, 1'b0, 16'h0000, 8'h00, 8'h00, 0);
      endT("write");
      cmd(32'h09, 1'b0, 16'h0001, 8'hF3, 8'hFF, 2);
      check({opAct, rwwBlk, cpuHalt, opKind}, {3'b100, OP_LOCK});
      waitIdle();
      rdChk(OFS_STAT, 32'h3300);
      cmd(32'h09, 1'b1, 16'h0001, 8'hFF, 8'hFF, 1);
      check({lpmOvr, lpmData}, 9'h1F3);
      endT("lock bits");
      cmd(32'h01, 1'b0, 16'h000E, 8'h11, 8'h22, 0);
      eeBusy <= 1'b1;
      bufChk(6'h07, 16'hFFFF, 1'b0);
      cmd(32'h09, 1'b1, 16'h0000, 8'hFF, 8'hFF, 0);
      check({31'h0, lpmOvr}, 32'h0);
      rdChk(OFS_CTRL, 32'h0);
      eeBusy <= 1'b0;
      endT("eeprom interlock");
      print_verdict();
   end
endmodule // flash_self_program_sequencer_test
